//--- core/irq_enable_defines.svh
`ifndef IRQ_ENABLE_DEFINES_SVH
`define IRQ_ENABLE_DEFINES_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define EVENT_IRQ_ENABLE_ADDR 12'h036c
`define ERROR_IRQ_ENABLE_ADDR 12'h0370
`define EVENT_IRQ_STATUS_ADDR 12'h0384
`define ERROR_IRQ_STATUS_ADDR 12'h0388

// ----------------------------------------
// Event enable field positions
// ----------------------------------------
`define FRAME_TIMER_BIT 29
`define FRAME_TRIGGER_BIT 28
`define CONV_EVENT_LSB 16
`define SEQ_CONV_DONE_BIT 4
`define SEQ_BUFFER_DONE_BIT 0

// ----------------------------------------
// Error enable field positions
// ----------------------------------------
`define SEQ_FRAME_FAULT_BIT 19
`define SEQ_TIMING_FAULT_BIT 18
`define SEQ_DATA_FAULT_BIT 17
`define SEQ_TRANSFER_FAULT_BIT 16
`define CONV_FAULT_LSB 0

// ----------------------------------------
// Writable masks and reset values
// ----------------------------------------
`define EVENT_ENABLE_MASK 32'h300f_0011
`define ERROR_ENABLE_MASK 32'h000f_000f
`define ENABLE_RESET 32'h0000_0000
`define APB_ADDR_WIDTH 12

`endif

//--- core/irq_enable_pkg.sv
`default_nettype none

package irq_enable_pkg;

  // ----------------------------------------
  // Bus carriers
  // ----------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  // Access phase states
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_t;

endpackage

`default_nettype wire

//--- core/reset_sync.sv
`timescale 1ns/1ns
`default_nettype none

module reset_sync (
  // Clock and raw reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Released reset
  output logic syncReset_n
);

  logic [1:0] stage_q;

  // ----------------------------------------
  // Two stage release
  // ----------------------------------------
  // Assert at once, release after two edges
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_q <= 2'h0;
    end else begin
      stage_q <= {stage_q[0], 1'b1};
    end
  end

  assign syncReset_n = stage_q[1];

endmodule

`default_nettype wire

//--- core/sticky_status.sv
`timescale 1ns/1ns
`default_nettype none

module sticky_status #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Events and gating
  input wire logic [WIDTH-1:0] eventPulse,
  input wire logic [WIDTH-1:0] enableBits,
  input wire logic [WIDTH-1:0] clearBits,
  // Status
  output logic [WIDTH-1:0] statusBits
);

  logic [WIDTH-1:0] status_q;
  logic [WIDTH-1:0] status_d;

  // ----------------------------------------
  // Sticky flags, set wins over clear
  // ----------------------------------------
  // Enable is the registered value, so it was set before the event
  always_comb begin
    status_d = (status_q & ~clearBits) | (eventPulse & enableBits);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  assign statusBits = status_q;

endmodule

`default_nettype wire

//--- core/dac_irq_enables.sv
// Contract
// - Status bit sets only if its enable was set before the event.
// - Event enable bit 29 enables frame timer events; resets to 0.
// - Event enable bit 28 enables frame trigger events; resets to 0.
// - Event enable bits 16..19 enable converter 1..4 convert events.
// - Event enable bit 4 enables sequencer conversions done; resets to 0.
// - Event enable bit 0 enables sequencer buffer done; resets to 0.
// - Error enable bit 19 enables sequencer frame faults; resets to 0.
// - Error enable bit 18 enables sequencer timing faults; resets to 0.
// - Error enable bit 17 enables sequencer data faults; resets to 0.
// - Error enable bit 16 enables sequencer transfer faults; resets to 0.
// - Error enable bits 0..3 enable converter 1..4 faults.
// - Other error enable bits are reserved with no function.
// - Interrupt request is high while any status bit is set.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "irq_enable_defines.svh"

module dac_irq_enables
  import irq_enable_pkg::*;
#(
  parameter int CONVERTERS = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // Event sources, one-cycle pulses
  input wire logic frame_timer_evt,
  input wire logic frame_trigger_evt,
  input wire logic [CONVERTERS-1:0] conv_event_evt,
  input wire logic seq_conversions_done_evt,
  input wire logic seq_buffer_done_evt,
  // Error sources, one-cycle pulses
  input wire logic seq_frame_fault_evt,
  input wire logic seq_timing_fault_evt,
  input wire logic seq_data_fault_evt,
  input wire logic seq_transfer_fault_evt,
  input wire logic [CONVERTERS-1:0] conv_fault_evt,
  // Interrupt request
  output logic irqRequest
);

  // ----------------------------------------
  // State and wires
  // ----------------------------------------
  typedef struct packed {
    bus_state_t bus;
    logic [31:0] eventEnable;
    logic [31:0] errorEnable;
    logic [31:0] rdata;
    logic slvErr;
  } regs_t;

  regs_t state_q;
  regs_t state_d;
  apb_req_t req;
  logic rst_n;
  logic [31:0] eventPulse;
  logic [31:0] errorPulse;
  logic [31:0] eventStatus;
  logic [31:0] errorStatus;
  logic [31:0] eventClear;
  logic [31:0] errorClear;
  logic writeNow;

  // Known register decode
  function automatic logic isMapped(input logic [11:0] addr);
    isMapped = (addr == `EVENT_IRQ_ENABLE_ADDR) ||
               (addr == `ERROR_IRQ_ENABLE_ADDR) ||
               (addr == `EVENT_IRQ_STATUS_ADDR) ||
               (addr == `ERROR_IRQ_STATUS_ADDR);
  endfunction

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  reset_sync u_reset_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .syncReset_n(rst_n)
  );

  // Bus request bundle
  always_comb begin
    req.psel = psel;
    req.penable = penable;
    req.pwrite = pwrite;
    req.paddr = paddr;
    req.pwdata = pwdata;
  end

  // ----------------------------------------
  // Event and error vectors
  // ----------------------------------------
  // Place each source at its enable position
  always_comb begin
    eventPulse = '0;
    errorPulse = '0;
    eventPulse[`FRAME_TIMER_BIT] = frame_timer_evt;
    eventPulse[`FRAME_TRIGGER_BIT] = frame_trigger_evt;
    eventPulse[`SEQ_CONV_DONE_BIT] = seq_conversions_done_evt;
    eventPulse[`SEQ_BUFFER_DONE_BIT] = seq_buffer_done_evt;
    errorPulse[`SEQ_FRAME_FAULT_BIT] = seq_frame_fault_evt;
    errorPulse[`SEQ_TIMING_FAULT_BIT] = seq_timing_fault_evt;
    errorPulse[`SEQ_DATA_FAULT_BIT] = seq_data_fault_evt;
    errorPulse[`SEQ_TRANSFER_FAULT_BIT] = seq_transfer_fault_evt;
    for (int i = 0; i < CONVERTERS; i++) begin
      eventPulse[`CONV_EVENT_LSB + i] = conv_event_evt[i];
      errorPulse[`CONV_FAULT_LSB + i] = conv_fault_evt[i];
    end
  end

  // Status write-one-to-clear on access phase
  assign writeNow = req.psel && req.penable && req.pwrite &&
                    (state_q.bus == BUS_IDLE);
  assign eventClear = (writeNow && req.paddr == `EVENT_IRQ_STATUS_ADDR) ?
                      req.pwdata : '0;
  assign errorClear = (writeNow && req.paddr == `ERROR_IRQ_STATUS_ADDR) ?
                      req.pwdata : '0;

  // ----------------------------------------
  // Sticky status banks
  // ----------------------------------------
  sticky_status #(.WIDTH(32)) u_event_status (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .eventPulse(eventPulse),
    .enableBits(state_q.eventEnable),
    .clearBits(eventClear),
    .statusBits(eventStatus)
  );

  sticky_status #(.WIDTH(32)) u_error_status (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .eventPulse(errorPulse),
    .enableBits(state_q.errorEnable),
    .clearBits(errorClear),
    .statusBits(errorStatus)
  );

  // ----------------------------------------
  // Register next state
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q.bus)
      BUS_IDLE: begin
        if (req.psel && req.penable) begin
          state_d.bus = BUS_ANSWER;
          state_d.slvErr = !isMapped(req.paddr);
          state_d.rdata = '0;
          if (req.pwrite) begin
            case (req.paddr)
              `EVENT_IRQ_ENABLE_ADDR: begin
                state_d.eventEnable = req.pwdata & `EVENT_ENABLE_MASK;
              end
              `ERROR_IRQ_ENABLE_ADDR: begin
                state_d.errorEnable = req.pwdata & `ERROR_ENABLE_MASK;
              end
              default: begin
                state_d.errorEnable = state_q.errorEnable;
              end
            endcase
          end else begin
            case (req.paddr)
              `EVENT_IRQ_ENABLE_ADDR: begin
                state_d.rdata = state_q.eventEnable;
              end
              `ERROR_IRQ_ENABLE_ADDR: begin
                state_d.rdata = state_q.errorEnable;
              end
              `EVENT_IRQ_STATUS_ADDR: begin
                state_d.rdata = eventStatus;
              end
              `ERROR_IRQ_STATUS_ADDR: begin
                state_d.rdata = errorStatus;
              end
              default: begin
                state_d.rdata = '0;
              end
            endcase
          end
        end
      end
      BUS_ANSWER: begin
        state_d.bus = BUS_IDLE;
      end
      default: begin
        state_d.bus = BUS_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q.bus <= BUS_IDLE;
      state_q.eventEnable <= `ENABLE_RESET;
      state_q.errorEnable <= `ENABLE_RESET;
      state_q.rdata <= 32'h0000_0000;
      state_q.slvErr <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pready = (state_q.bus == BUS_ANSWER);
  assign pslverr = pready && state_q.slvErr;
  assign prdata = state_q.rdata;
  assign irqRequest = |{eventStatus, errorStatus};

endmodule

`default_nettype wire

//--- dv/dac_irq_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "irq_enable_defines.svh"

module dac_irq_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // Interrupt
  input wire logic irqRequest
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Address decode of the answered access
  wire logic hitEv = paddr == `EVENT_IRQ_ENABLE_ADDR;
  wire logic hitEr = paddr == `ERROR_IRQ_ENABLE_ADDR;
  wire logic hitSt = paddr == `EVENT_IRQ_STATUS_ADDR ||
                     paddr == `ERROR_IRQ_STATUS_ADDR;
  wire logic hit = hitEv || hitEr || hitSt;
  wire logic rdAns = pready && !pwrite;

  // Bus answer timing
  a_ready_wait: assert property ($rose(penable) |-> !pready ##1 pready)
    else $error("pready not one cycle after access start");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_qual: assert property (pslverr |-> pready)
    else $error("pslverr outside an answer");
  a_unmapped_err: assert property (pready && !hit |-> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (pready && hit |-> !pslverr)
    else $error("mapped access refused");

  // Reserved bits and the request line
  a_event_resv: assert property (
    rdAns && hitEv |-> (prdata & ~`EVENT_ENABLE_MASK) == 32'h0000_0000)
    else $error("event enable reserved bits not zero");
  a_error_resv: assert property (
    rdAns && hitEr |-> (prdata & ~`ERROR_ENABLE_MASK) == 32'h0000_0000)
    else $error("error enable reserved bits not zero");
  a_irq_fall: assert property (
    $fell(irqRequest) |-> $past(psel && penable && pwrite && hitSt))
    else $error("request dropped without a status clear");
endmodule

bind dac_irq_enables dac_irq_sva i_sva (.sys_clk(sys_clk),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .irqRequest(irqRequest));
`default_nettype wire

//--- dv/evt_source.sv
`timescale 1ns/1ns
`default_nettype none

module evt_source (
  // Clock
  input wire logic sys_clk,
  // Command
  input wire logic go,
  input wire logic [15:0] mask,
  // Event pulses
  output logic [15:0] evt
);
  // One-cycle pulse per command, quiet otherwise
  always_ff @(posedge sys_clk) begin
    evt <= go ? mask : 16'h0000;
  end
endmodule
`default_nettype wire

//--- dv/dac_sequencer_irq_enables_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module dac_sequencer_irq_enables_tb_top;
  logic sys_clk = 0, reset_n = 0, go = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0000;
  logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
  logic [15:0] mask = 16'h0000, evt;
  logic pready, pslverr, err, irqRequest;
  int fails = 0, checked = 0;
  typedef struct {logic [11:0] a; logic [31:0] d, e;} row_t;
  row_t rows [4] = '{'{12'h036c, 32'hffff_ffff, 32'h300f_0011},
    '{12'h0370, 32'hffff_ffff, 32'h000f_000f},
    '{12'h036c, 32'hcfa5_5aee, 32'h0005_0000},
    '{12'h0370, 32'hfffa_fff5, 32'h000a_0005}};

  // ----------------------------------------
  // Design and event source
  // ----------------------------------------
  dac_irq_enables i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .seq_buffer_done_evt(evt[0]), .seq_conversions_done_evt(evt[1]),
    .conv_event_evt(evt[5:2]), .frame_trigger_evt(evt[6]),
    .frame_timer_evt(evt[7]), .conv_fault_evt(evt[11:8]),
    .seq_transfer_fault_evt(evt[12]), .seq_data_fault_evt(evt[13]),
    .seq_timing_fault_evt(evt[14]), .seq_frame_fault_evt(evt[15]),
    .irqRequest(irqRequest));
  evt_source i_src (.sys_clk(sys_clk), .go(go), .mask(mask), .evt(evt));

  // Clock
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; answer taken at the edge where pready is high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task fire(input logic [15:0] m);
    @(posedge sys_clk);
    mask <= m;
    go <= 1;
    @(posedge sys_clk);
    go <= 0;
    repeat (2) @(posedge sys_clk);
  endtask

  task finish_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog
  initial begin
    #200000;
    fails++;
    finish_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1;
    repeat (3) @(posedge sys_clk);
    foreach (rows[i]) begin
      apb(1, rows[i].a, rows[i].d);
      apb(0, rows[i].a, 32'h0000_0000);
      check(rd, rows[i].e);
    end
    // Second reset clears enables left set by the rows
    reset_n <= 0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1;
    repeat (3) @(posedge sys_clk);
    apb(0, 12'h036c, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(0, 12'h0370, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    // Events while disabled leave nothing behind
    fire(16'hffff);
    apb(1, 12'h036c, 32'hffff_ffff);
    apb(1, 12'h0370, 32'hffff_ffff);
    apb(0, 12'h0384, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check(irqRequest, 32'h0000_0000);
    // All sources enabled, then cleared one register at a time
    fire(16'hffff);
    apb(0, 12'h0384, 32'h0000_0000);
    check(rd, 32'h300f_0011);
    apb(0, 12'h0388, 32'h0000_0000);
    check(rd, 32'h000f_000f);
    check(irqRequest, 32'h0000_0001);
    apb(1, 12'h0384, 32'hffff_ffff);
    check(irqRequest, 32'h0000_0001);
    apb(1, 12'h0388, 32'hffff_ffff);
    check(irqRequest, 32'h0000_0000);
    // Single converter bits among neighbours
    apb(1, 12'h036c, 32'h0002_0000);
    apb(1, 12'h0370, 32'h0000_0004);
    fire(16'h0f0c);
    apb(0, 12'h0384, 32'h0000_0000);
    check(rd, 32'h0002_0000);
    apb(0, 12'h0388, 32'h0000_0000);
    check(rd, 32'h0000_0004);
    // Unmapped address is refused
    apb(0, 12'h0100, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check(err, 32'h0000_0001);
    finish_test();
  end
endmodule
`default_nettype wire
